/* File: logic/tec_counter.sv */
// timer/event counter with preload, pulse-width mode and divider output
//
// Functional notes
// - single 8-bit up-only counter
// - control bit 5 picks rtc or internal clock
// - write stores preload, read returns live count
// - mode field: 01 event, 10 timer, 11 pulse
// - overflow past FF reloads and sets flag
// - pulse mode counts until input level returns
// - control bit 3 picks edge; 0 rising
// - finished measurement holds until enable set again
// - pulse measurement starts on edge, not level
// - pulse mode overflow reloads and raises flag
// - counting only while enable bit is set
// - hardware clears enable only after pulse measurement
// - overflow is a halt wake-up source
// - irq enable low blocks service, flag sets
// - write while disabled loads counter too
// - write while enabled changes preload only
// - count clock blocked during count register read
// - control bits 0 to 2 read zero
// - divider pad: latch 0 drives divider, 1 drives 0
// - divider frequency is the selected count source over 2(256-N)
`include "tec_regs.svh"
`default_nettype none
module tec_counter (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// register access port
	input  wire tec_pkg::tec_bus_t bus,
	output logic      [7:0] rdata,
	// count sources
	input  wire logic       internal_count_clock,
	input  wire logic       rtc_timeout,
	input  wire logic       count_input_and_value,
	// interrupt control
	input  wire logic       counter_irq_enable,
	input  wire logic       flag_clear,
	output logic            overflow_request_flag,
	output logic            irq_request,
	output logic            wake_up,
	// divider output
	input  wire logic       divider_option,
	input  wire logic       port_a_bit3,
	output logic            pad_out,
	output logic            pad_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	tec_pkg::tec_ctrl_t     ctrl_ff, nxt_ctrl;
	tec_pkg::tec_pw_state_t pw_ff, nxt_pw;
	logic [7:0] count_ff, nxt_count;
	logic [7:0] preload_ff, nxt_preload;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       flag_ff, nxt_flag;
	logic       div_ff, nxt_div;
	logic       pin_ff, src_ff;
	logic       rtc_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	// ------------------------------------------------------------
	// edge detection of the selected sources
	// ------------------------------------------------------------
	logic src_lvl, src_tick, pin_edge, pin_back, int_tick, tick;
	logic wr_cnt, wr_ctl, rd_cnt, ovf;

	always_comb begin
		wr_cnt   = bus.wr && hit(bus.addr, `TEC_ADDR_COUNT);
		wr_ctl   = bus.wr && hit(bus.addr, `TEC_ADDR_CONTROL);
		rd_cnt   = bus.rd && hit(bus.addr, `TEC_ADDR_COUNT);
		// internal source: rtc time-out or option-selected clock
		src_lvl  = ctrl_ff.clock_source_select ? internal_count_clock : rtc_timeout;
		int_tick = src_lvl && !src_ff;
		// edge_polarity 0 means rising, as the bit table reads
		pin_edge = ctrl_ff.edge_polarity ? (pin_ff && !count_input_and_value)
		                                 : (!pin_ff && count_input_and_value);
		pin_back = ctrl_ff.edge_polarity ? (!pin_ff && count_input_and_value)
		                                 : (pin_ff && !count_input_and_value);
		case (ctrl_ff.mode)
			`TEC_MODE_EVENT: src_tick = pin_edge;
			`TEC_MODE_TIMER: src_tick = int_tick;
			`TEC_MODE_PULSE: src_tick = int_tick && (pw_ff == tec_pkg::TEC_PW_COUNT);
			default:         src_tick = 1'b0;
		endcase
		// a count register read freezes the count for that cycle; the edge is lost
		tick = src_tick && ctrl_ff.count_enable && !rd_cnt;
		ovf  = tick && (count_ff == `TEC_COUNT_MAX);
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_ctrl    = ctrl_ff;
		nxt_pw      = pw_ff;
		nxt_count   = count_ff;
		nxt_preload = preload_ff;
		nxt_flag    = flag_ff;
		nxt_div     = div_ff;
		nxt_rdata   = rdata_ff;
		// pulse measurement sequencing
		case (pw_ff)
			tec_pkg::TEC_PW_IDLE: begin
				if (ctrl_ff.count_enable && ctrl_ff.mode == `TEC_MODE_PULSE)
					nxt_pw = tec_pkg::TEC_PW_ARMED;
			end
			tec_pkg::TEC_PW_ARMED: begin
				if (!ctrl_ff.count_enable || ctrl_ff.mode != `TEC_MODE_PULSE)
					nxt_pw = tec_pkg::TEC_PW_IDLE;
				else if (pin_edge)
					nxt_pw = tec_pkg::TEC_PW_COUNT;
			end
			tec_pkg::TEC_PW_COUNT: begin
				if (!ctrl_ff.count_enable || ctrl_ff.mode != `TEC_MODE_PULSE) begin
					nxt_pw = tec_pkg::TEC_PW_IDLE;
				end else if (pin_back) begin
					// stop and hold result until enable is written again
					nxt_ctrl.count_enable = 1'b0;
					nxt_pw                = tec_pkg::TEC_PW_IDLE;
				end
			end
			default: nxt_pw = tec_pkg::TEC_PW_IDLE;
		endcase
		// counting, up only
		if (ovf) begin
			nxt_count = preload_ff;
			nxt_div   = !div_ff;
		end else if (tick) begin
			nxt_count = count_ff + 8'h01;
		end
		// software writes
		if (wr_cnt) begin
			nxt_preload = bus.wdata;
			if (!ctrl_ff.count_enable)
				nxt_count = bus.wdata;
		end
		if (wr_ctl) begin
			nxt_ctrl.mode                = {bus.wdata[`TEC_BIT_MODE_HI], bus.wdata[`TEC_BIT_MODE_LO]};
			nxt_ctrl.clock_source_select = bus.wdata[`TEC_BIT_CLKSEL];
			nxt_ctrl.count_enable        = bus.wdata[`TEC_BIT_ENABLE];
			nxt_ctrl.edge_polarity       = bus.wdata[`TEC_BIT_EDGE];
			if (!bus.wdata[`TEC_BIT_ENABLE])
				nxt_pw = tec_pkg::TEC_PW_IDLE;
		end
		// flag: set wins over clear
		if (flag_clear)
			nxt_flag = 1'b0;
		if (ovf)
			nxt_flag = 1'b1;
		// read data, low control bits read zero
		if (bus.rd) begin
			if (hit(bus.addr, `TEC_ADDR_COUNT))
				nxt_rdata = count_ff;
			else if (hit(bus.addr, `TEC_ADDR_CONTROL))
				nxt_rdata = {ctrl_ff.mode[1], ctrl_ff.mode[0], ctrl_ff.clock_source_select,
				             ctrl_ff.count_enable, ctrl_ff.edge_polarity, 3'h0};
			else
				nxt_rdata = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff    <= tec_pkg::tec_ctrl_t'(5'h01);
			pw_ff      <= tec_pkg::TEC_PW_IDLE;
			count_ff   <= `TEC_COUNT_RESET;
			preload_ff <= `TEC_COUNT_RESET;
			rdata_ff   <= 8'h00;
			flag_ff    <= 1'b0;
			div_ff     <= 1'b0;
			pin_ff     <= 1'b0;
			src_ff     <= 1'b0;
			rtc_ff     <= 1'b0;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			pw_ff      <= nxt_pw;
			count_ff   <= nxt_count;
			preload_ff <= nxt_preload;
			rdata_ff   <= nxt_rdata;
			flag_ff    <= nxt_flag;
			div_ff     <= nxt_div;
			pin_ff     <= count_input_and_value;
			src_ff     <= src_lvl;
			rtc_ff     <= ovf;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// latch 0 passes the divider; latch 1 or option off drives 0
	always_comb begin
		rdata                 = rdata_ff;
		overflow_request_flag = flag_ff;
		irq_request           = flag_ff && counter_irq_enable;
		wake_up               = rtc_ff;
		pad_oe                = divider_option;
		pad_out               = divider_option && !port_a_bit3 && div_ff;
	end

endmodule
`default_nettype wire

/* File: pkg/tec_regs.svh */
// register offsets, field positions and reset values of the timer/event counter
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

`define TEC_ADDR_COUNT     8'h0D
`define TEC_ADDR_CONTROL   8'h0E
`define TEC_BIT_EDGE       3
`define TEC_BIT_ENABLE     4
`define TEC_BIT_CLKSEL     5
`define TEC_BIT_MODE_LO    6
`define TEC_BIT_MODE_HI    7
`define TEC_CTRL_RESET     8'h08
`define TEC_COUNT_RESET    8'h00
`define TEC_COUNT_MAX      8'hFF
`define TEC_MODE_EVENT     2'h1
`define TEC_MODE_TIMER     2'h2
`define TEC_MODE_PULSE     2'h3

`endif

/* File: pkg/tec_pkg.sv */
// types shared by the timer/event counter
`default_nettype none
package tec_pkg;

	typedef struct packed {
		logic [1:0] mode;
		logic       clock_source_select;
		logic       count_enable;
		logic       edge_polarity;
	} tec_ctrl_t;

	typedef enum logic [2:0] {
		TEC_PW_IDLE  = 3'b001,
		TEC_PW_ARMED = 3'b010,
		TEC_PW_COUNT = 3'b100
	} tec_pw_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tec_bus_t;

endpackage
`default_nettype wire

/* File: verif/tec_counter_properties.sv */
// port checks for the timer/event counter
`include "tec_regs.svh"
`default_nettype none
module tec_counter_properties (
	// clock and reset
	input wire logic              clock,
	input wire logic              rst_n,
	// register access
	input wire tec_pkg::tec_bus_t bus,
	input wire logic [7:0]        rdata,
	// flag, wake and pad
	input wire logic              counter_irq_enable,
	input wire logic              flag_clear,
	input wire logic              overflow_request_flag,
	input wire logic              irq_request,
	input wire logic              wake_up,
	input wire logic              port_a_bit3,
	input wire logic              pad_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	irq_gate_a: assert property (
		irq_request == (overflow_request_flag && counter_irq_enable)) else $error("irq gating");
	pad_quiet_a: assert property (port_a_bit3 && $past(port_a_bit3) |-> !pad_out)
		else $error("pad not low");
	wake_pulse_a: assert property (wake_up |=> !wake_up)
		else $error("wake too long");
	flag_wake_a: assert property ($rose(overflow_request_flag) |-> wake_up)
		else $error("no wake");
	flag_sticky_a: assert property (overflow_request_flag && !flag_clear |=> overflow_request_flag)
		else $error("flag lost");
	rdata_hold_a: assert property (!bus.rd |=> $stable(rdata))
		else $error("rdata moved");
	ctrl_low_a: assert property (bus.rd && bus.addr == `TEC_ADDR_CONTROL |=> rdata[2:0] == 3'h0)
		else $error("low bits set");
	hole_read_a: assert property (bus.rd && bus.addr > `TEC_ADDR_CONTROL |=> rdata == 8'h00)
		else $error("hole read");
endmodule
bind tec_counter tec_counter_properties u_props (.clock(clock), .rst_n(rst_n), .bus(bus),
	.rdata(rdata), .counter_irq_enable(counter_irq_enable), .flag_clear(flag_clear),
	.overflow_request_flag(overflow_request_flag), .irq_request(irq_request),
	.wake_up(wake_up), .port_a_bit3(port_a_bit3), .pad_out(pad_out));
`default_nettype wire

/* File: verif/tec_event_src.sv */
// external event pin driver
`default_nettype none
module tec_event_src (
	// clock
	input wire logic clock,
	// event pin
	output var logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'b0;
	task automatic pulse(input int hi, input int lo);
		#5 pin = 1'b1;
		repeat (hi) @(posedge clock);
		#5 pin = 1'b0;
		repeat (lo) @(posedge clock);
	endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the timer/event counter
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clock = 0, rst_n = 0, icc = 0, irq_en = 0, fclr = 0, latch = 0, rtc = 0;
	logic              pin, flag, irq, wake, pad;
	logic [7:0]        rdata;
	tec_pkg::tec_bus_t bus = '0;
	int                failures = 0, cmp_count = 0, cyc = 0;
	// address, write data, read-back
	logic [7:0]        rows [5][3] = '{'{8'h0D, 8'h5A, 8'h5A}, '{8'h0E, 8'h37, 8'h30},
		'{8'h0D, 8'h11, 8'h5A}, '{8'h0E, 8'h00, 8'h00}, '{8'h20, 8'h77, 8'h00}};
	tec_event_src src (.clock(clock), .pin(pin));
	tec_counter DUT (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.internal_count_clock(icc), .rtc_timeout(rtc), .count_input_and_value(pin),
		.counter_irq_enable(irq_en), .flag_clear(fclr), .overflow_request_flag(flag),
		.irq_request(irq), .wake_up(wake), .divider_option(1'b1), .port_a_bit3(latch),
		.pad_out(pad), .pad_oe());
	always #50 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#5 bus = '{1'b1, 1'b0, a, d};
		@(posedge clock);
		#5 bus.wr = 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		#5 bus = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		#5 bus.rd = 1'b0;
		chk(rdata, e);
	endtask
	// no reads while ticking, so no edge is lost to the read block
	task tick(input int n);
		repeat (n) begin
			@(posedge clock);
			#5 icc = 1'b1;
			@(posedge clock);
			#5 icc = 1'b0;
		end
	endtask
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		#5 rst_n = 1'b1;
		rchk(8'h0E, 8'h08);
		foreach (rows[i]) begin
			wr(rows[i][0], rows[i][1]);
			rchk(rows[i][0], rows[i][2]);
		end
		wr(8'h0D, 8'hFD);
		wr(8'h0E, 8'hB0);
		tick(2);
		chk({7'h0, flag}, 8'h00);
		tick(1);
		chk({7'h0, flag}, 8'h01);
		chk({7'h0, irq}, 8'h00);
		chk({7'h0, pad}, 8'h01);
		irq_en = 1'b1;
		latch = 1'b1;
		#1 chk({6'h0, irq, pad}, 8'h02);
		wr(8'h0E, 8'h00);
		tick(2);
		rchk(8'h0D, 8'hFD);
		fclr = 1'b1;
		@(posedge clock);
		#5 fclr = 1'b0;
		chk({7'h0, flag}, 8'h00);
		wr(8'h0D, 8'h00);
		wr(8'h0E, 8'h50);
		repeat (3) src.pulse(3, 4);
		wr(8'h0E, 8'h58);
		repeat (3) src.pulse(3, 4);
		wr(8'h0E, 8'h00);
		rchk(8'h0D, 8'h06);
		wr(8'h0D, 8'h00);
		wr(8'h0E, 8'hF0);
		repeat (2) begin
			fork
				src.pulse(10, 4);
				begin
					repeat (2) @(posedge clock);
					tick(3);
				end
			join
		end
		rchk(8'h0D, 8'h03);
		rchk(8'h0E, 8'hE0);
		// rtc source selected: internal clock edges must not count
		wr(8'h0D, 8'h10);
		wr(8'h0E, 8'h90);
		tick(2);
		repeat (2) begin
			@(posedge clock);
			#5 rtc = 1'b1;
			@(posedge clock);
			#5 rtc = 1'b0;
		end
		wr(8'h0E, 8'h00);
		rchk(8'h0D, 8'h12);
		tally_and_finish();
	end
endmodule
`default_nettype wire
